// [rtl/fsd_regs.svh]
// register offsets, field positions, reset values and timing counts
`ifndef FSD_REGS_SVH
`define FSD_REGS_SVH

`define FSD_ADDR_W 8
`define FSD_CW0_OFS 8'h00
`define FSD_CW1_OFS 8'h04
`define FSD_STAT_OFS 8'h08

`define FSD_FRAC_LSB 0
`define FSD_INT_LSB 15
`define FSD_SYNTH_EN_BIT 28
`define FSD_MUX_LSB 29

`define FSD_RDIV_LSB 4
`define FSD_CKDIV_LSB 8
`define FSD_OSC_EN_BIT 12
`define FSD_HALVE_BIT 13
`define FSD_BIAS_LSB 16
`define FSD_ADJ_LSB 20

`define FSD_STAT_READY_BIT 0
`define FSD_STAT_LOCK_BIT 1
`define FSD_STAT_FB_LSB 8

`define FSD_CW0_RST 32'h000F_8000
`define FSD_CW1_RST 32'h0000_1410

`define FSD_INT_MIN 8'h1F
`define FSD_CLK_NS 8
`define FSD_REG_READY_NS 50000
`define FSD_REG_READY_CYC ((`FSD_REG_READY_NS + `FSD_CLK_NS - 1) / `FSD_CLK_NS)
`define FSD_LOCK_SET_NS 8'h0F
`define FSD_LOCK_CLR_NS 8'h19
`define FSD_LOCK_CYCLES 3'h5

`define FSD_RESP_OKAY 2'h0
`define FSD_RESP_SLVERR 2'h2

`endif

// [rtl/fsd_pkg.sv]
// types shared by the synthesizer control design
`default_nettype none
package fsd_pkg;

  typedef enum logic [2:0] {
    FSD_MUX_REG_READY = 3'b000,
    FSD_MUX_LOCK = 3'b001
  } fsd_mux_type;

  typedef enum logic [0:0] {
    FSD_UNLOCKED = 1'b0,
    FSD_LOCKED = 1'b1
  } fsd_lock_type;

  typedef struct packed {
    logic [2:0] mux_select_field;
    logic synth_enable_bit;
    logic [7:0] int_value;
    logic [14:0] frac_value;
    logic [3:0] vco_adjust_bits;
    logic [3:0] vco_bias_field;
    logic vco_halve_enable;
    logic osc_enable_bit;
    logic [3:0] clock_out_divide_field;
    logic [2:0] ref_div_field;
  } fsd_cfg_type;

endpackage
`default_nettype wire

// [rtl/fsd_ref_clock_output_div.sv]
// even-ratio divider for the reference clock output
`timescale 1ns/1ns
`default_nettype none
module fsd_ref_clock_output_div (
  input wire logic clk_sys,
  input wire logic clear,
  input wire logic osc_run,
  input wire logic [3:0] divide_field,
  output logic clk_out_q
);
  logic [3:0] cnt_q;
  logic [3:0] cnt_d;
  logic clk_out_d;

  always_comb begin
    cnt_d = cnt_q;
    clk_out_d = clk_out_q;
    if (divide_field == 4'h0 || !osc_run) begin
      cnt_d = 4'h0;
      clk_out_d = 1'b0;
    end else if (cnt_q >= divide_field - 4'h1) begin
      cnt_d = 4'h0;
      clk_out_d = !clk_out_q;
    end else begin
      cnt_d = cnt_q + 4'h1;
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clear) begin
      cnt_q <= 4'h0;
      clk_out_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      clk_out_q <= clk_out_d;
    end
  end
endmodule
`default_nettype wire

// [rtl/fsd_synth_ctrl.sv]
// synthesizer digital control with its AXI4-Lite register slave
//
// Overview of operation
// - oscillator runs while enable set, default on
// - clock output divides by even 2..30
// - clock output defaults to divide by eight
// - divide field zero stops clock output
// - three-bit reference divider 1..7 feeds detector
// - reference divider defaults to one
// - select field chooses multiplexer output signal
// - multiplexer defaults to regulator ready
// - lock after five cycles below 15 ns
// - lock holds until 25 ns error
// - chip enable low clears all registers except the register bus state
// - eight-bit integer plus 15-bit fractional divider
// - integer divide value never below 31
// - output is ref over R times N
// - halve enable inserts divide by two
// - two-bit adjust field recenters vco
// - vco powered only with synth enable
//
// The address map and the AXI4-Lite slave port were decided locally.
`timescale 1ns/1ns
`default_nettype none
`include "fsd_regs.svh"
module fsd_synth_ctrl
  import fsd_pkg::*;
#(
  parameter int REG_READY_CYC = `FSD_REG_READY_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chip_enable,
  input wire logic [7:0] phase_error_ns,
  input wire logic [`FSD_ADDR_W-1:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [`FSD_ADDR_W-1:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic regulator_enable_q,
  output logic osc_enable_q,
  output logic ref_clock_output,
  output logic phase_detector_tick_q,
  output logic [8:0] fb_divide_q,
  output logic vco_enable_q,
  output logic vco_halve_enable_q,
  output logic [1:0] vco_adjust_field_q,
  output logic [3:0] vco_bias_field_q,
  output logic mux_out_q
);

  function automatic logic [31:0] merge_bytes(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        r[i*8 +: 8] = data[i*8 +: 8];
      end
    end
    return r;
  endfunction

  function automatic logic is_mapped(input logic [`FSD_ADDR_W-1:0] a);
    return a == `FSD_CW0_OFS || a == `FSD_CW1_OFS || a == `FSD_STAT_OFS;
  endfunction

  logic clear;
  assign clear = rst || !chip_enable;

  // ---------------- register bus ----------------
  logic aw_have_q, aw_have_d, w_have_q, w_have_d;
  logic [`FSD_ADDR_W-1:0] awaddr_q, awaddr_d;
  logic [31:0] wdata_q, wdata_d;
  logic [3:0] wstrb_q, wstrb_d;
  logic awready_d, wready_d, bvalid_d, arready_d, rvalid_d;
  logic [1:0] bresp_d, rresp_d;
  logic [31:0] rdata_d;
  logic wr_fire;
  logic [31:0] cw0_q, cw0_d, cw1_q, cw1_d, stat_word;
  logic ready_q, ready_d;
  logic [15:0] ready_cnt_q, ready_cnt_d;
  fsd_lock_type lock_q, lock_d;

  assign stat_word = {15'h0000, fb_divide_q, 6'h00,
                      lock_q == FSD_LOCKED, ready_q};

  always_comb begin
    aw_have_d = aw_have_q;
    w_have_d = w_have_q;
    awaddr_d = awaddr_q;
    wdata_d = wdata_q;
    wstrb_d = wstrb_q;
    bvalid_d = s_axi_bvalid;
    bresp_d = s_axi_bresp;
    rvalid_d = s_axi_rvalid;
    rresp_d = s_axi_rresp;
    rdata_d = s_axi_rdata;
    if (s_axi_awvalid && s_axi_awready) begin
      aw_have_d = 1'b1;
      awaddr_d = s_axi_awaddr;
    end
    if (s_axi_wvalid && s_axi_wready) begin
      w_have_d = 1'b1;
      wdata_d = s_axi_wdata;
      wstrb_d = s_axi_wstrb;
    end
    if (s_axi_bvalid && s_axi_bready) begin
      bvalid_d = 1'b0;
    end
    wr_fire = aw_have_q && w_have_q && !s_axi_bvalid;
    if (wr_fire) begin
      aw_have_d = 1'b0;
      w_have_d = 1'b0;
      bvalid_d = 1'b1;
      bresp_d = is_mapped(awaddr_q) ? `FSD_RESP_OKAY : `FSD_RESP_SLVERR;
    end
    awready_d = !aw_have_d && !bvalid_d;
    wready_d = !w_have_d && !bvalid_d;
    if (s_axi_rvalid && s_axi_rready) begin
      rvalid_d = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      rvalid_d = 1'b1;
      rresp_d = `FSD_RESP_OKAY;
      case (s_axi_araddr)
        `FSD_CW0_OFS: rdata_d = cw0_q;
        `FSD_CW1_OFS: rdata_d = cw1_q;
        `FSD_STAT_OFS: rdata_d = stat_word;
        default: begin
          rdata_d = 32'h0000_0000;
          rresp_d = `FSD_RESP_SLVERR;
        end
      endcase
    end
    arready_d = !rvalid_d;
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      aw_have_q <= 1'b0;
      w_have_q <= 1'b0;
      awaddr_q <= '0;
      wdata_q <= 32'h0000_0000;
      wstrb_q <= 4'h0;
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rresp <= 2'h0;
      s_axi_rdata <= 32'h0000_0000;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      awaddr_q <= awaddr_d;
      wdata_q <= wdata_d;
      wstrb_q <= wstrb_d;
      s_axi_awready <= awready_d;
      s_axi_wready <= wready_d;
      s_axi_bvalid <= bvalid_d;
      s_axi_bresp <= bresp_d;
      s_axi_arready <= arready_d;
      s_axi_rvalid <= rvalid_d;
      s_axi_rresp <= rresp_d;
      s_axi_rdata <= rdata_d;
    end
  end

  // ---------------- control words and regulator ----------------
  fsd_cfg_type cfg;
  logic [7:0] int_eff;

  always_comb begin
    cw0_d = cw0_q;
    cw1_d = cw1_q;
    ready_cnt_d = ready_cnt_q;
    ready_d = ready_q;
    if (ready_cnt_q >= 16'(REG_READY_CYC - 1)) begin
      ready_d = 1'b1;
    end else begin
      ready_cnt_d = ready_cnt_q + 16'h0001;
    end
    // writes before the regulator settles are dropped, still answered
    if (wr_fire && ready_q) begin
      if (awaddr_q == `FSD_CW0_OFS) begin
        cw0_d = merge_bytes(cw0_q, wdata_q, wstrb_q);
      end
      if (awaddr_q == `FSD_CW1_OFS) begin
        cw1_d = merge_bytes(cw1_q, wdata_q, wstrb_q);
      end
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clear) begin
      cw0_q <= `FSD_CW0_RST;
      cw1_q <= `FSD_CW1_RST;
      ready_cnt_q <= 16'h0000;
      ready_q <= 1'b0;
    end else begin
      cw0_q <= cw0_d;
      cw1_q <= cw1_d;
      ready_cnt_q <= ready_cnt_d;
      ready_q <= ready_d;
    end
  end

  always_comb begin
    cfg.mux_select_field = cw0_q[`FSD_MUX_LSB +: 3];
    cfg.synth_enable_bit = cw0_q[`FSD_SYNTH_EN_BIT];
    cfg.int_value = cw0_q[`FSD_INT_LSB +: 8];
    cfg.frac_value = cw0_q[`FSD_FRAC_LSB +: 15];
    cfg.vco_adjust_bits = {2'b00, cw1_q[`FSD_ADJ_LSB +: 2]};
    cfg.vco_bias_field = cw1_q[`FSD_BIAS_LSB +: 4];
    cfg.vco_halve_enable = cw1_q[`FSD_HALVE_BIT];
    cfg.osc_enable_bit = cw1_q[`FSD_OSC_EN_BIT];
    cfg.clock_out_divide_field = cw1_q[`FSD_CKDIV_LSB +: 4];
    cfg.ref_div_field = cw1_q[`FSD_RDIV_LSB +: 3];
    int_eff = (cfg.int_value < `FSD_INT_MIN) ? `FSD_INT_MIN
                                            : cfg.int_value;
  end

  // ---------------- dividers and lock detect ----------------
  logic [2:0] rcnt_q, rcnt_d, r_eff;
  logic tick_d;
  logic [14:0] acc_q, acc_d;
  logic [15:0] acc_sum;
  logic [8:0] fb_d;
  logic [2:0] lcnt_q, lcnt_d;
  logic osc_run;

  assign osc_run = cfg.osc_enable_bit;

  always_comb begin
    rcnt_d = rcnt_q;
    tick_d = 1'b0;
    acc_d = acc_q;
    fb_d = fb_divide_q;
    lcnt_d = lcnt_q;
    lock_d = lock_q;
    acc_sum = 16'h0000;
    // field zero acts as ratio one
    r_eff = (cfg.ref_div_field == 3'h0) ? 3'h1 : cfg.ref_div_field;
    if (osc_run) begin
      if (rcnt_q >= r_eff - 3'h1) begin
        rcnt_d = 3'h0;
        tick_d = 1'b1;
      end else begin
        rcnt_d = rcnt_q + 3'h1;
      end
    end
    if (!cfg.synth_enable_bit) begin
      acc_d = 15'h0000;
      fb_d = 9'h000;
      lcnt_d = 3'h0;
      lock_d = FSD_UNLOCKED;
    end else if (phase_detector_tick_q) begin
      acc_sum = {1'b0, acc_q} + {1'b0, cfg.frac_value};
      acc_d = acc_sum[14:0];
      // mean modulus is int plus frac over 2^15
      fb_d = {1'b0, int_eff} + {8'h00, acc_sum[15]};
      case (lock_q)
        FSD_UNLOCKED: begin
          // five good comparisons in a row
          if (phase_error_ns < `FSD_LOCK_SET_NS) begin
            lcnt_d = lcnt_q + 3'h1;
            if (lcnt_q + 3'h1 >= `FSD_LOCK_CYCLES) begin
              lock_d = FSD_LOCKED;
              lcnt_d = 3'h0;
            end
          end else begin
            lcnt_d = 3'h0;
          end
        end
        FSD_LOCKED: begin
          if (phase_error_ns >= `FSD_LOCK_CLR_NS) begin
            lock_d = FSD_UNLOCKED;
          end
        end
        default: lock_d = FSD_UNLOCKED;
      endcase
    end
  end

  always_ff @(posedge clk_sys) begin
    if (clear) begin
      rcnt_q <= 3'h0;
      phase_detector_tick_q <= 1'b0;
      acc_q <= 15'h0000;
      fb_divide_q <= 9'h000;
      lcnt_q <= 3'h0;
      lock_q <= FSD_UNLOCKED;
    end else begin
      rcnt_q <= rcnt_d;
      phase_detector_tick_q <= tick_d;
      acc_q <= acc_d;
      fb_divide_q <= fb_d;
      lcnt_q <= lcnt_d;
      lock_q <= lock_d;
    end
  end

  // ---------------- pin outputs ----------------
  logic mux_d;

  always_comb begin
    case (cfg.mux_select_field)
      // code zero ready, code one lock
      FSD_MUX_REG_READY: mux_d = ready_q;
      FSD_MUX_LOCK: mux_d = (lock_q == FSD_LOCKED);
      default: mux_d = 1'b0;
    endcase
  end

  always_ff @(posedge clk_sys) begin
    if (clear) begin
      regulator_enable_q <= 1'b0;
      osc_enable_q <= 1'b0;
      vco_enable_q <= 1'b0;
      vco_halve_enable_q <= 1'b0;
      vco_adjust_field_q <= 2'h0;
      vco_bias_field_q <= 4'h0;
      mux_out_q <= 1'b0;
    end else begin
      regulator_enable_q <= 1'b1;
      osc_enable_q <= cfg.osc_enable_bit;
      vco_enable_q <= cfg.synth_enable_bit;
      vco_halve_enable_q <= cfg.vco_halve_enable;
      vco_adjust_field_q <= cfg.vco_adjust_bits[1:0];
      vco_bias_field_q <= cfg.vco_bias_field;
      mux_out_q <= mux_d;
    end
  end

  fsd_ref_clock_output_div u_ref_clock_output (
    .clk_sys(clk_sys),
    .clear(clear),
    .osc_run(osc_run),
    .divide_field(cfg.clock_out_divide_field),
    .clk_out_q(ref_clock_output)
  );
endmodule
`default_nettype wire

// [testbench/fsd_synth_ctrl_assertions.sv]
// port-level property checks for the synthesizer control block
`timescale 1ns/1ns
`default_nettype none
module fsd_synth_ctrl_assertions (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic chip_enable,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic regulator_enable_q,
  input wire logic osc_enable_q,
  input wire logic ref_clock_output,
  input wire logic phase_detector_tick_q,
  input wire logic [8:0] fb_divide_q,
  input wire logic vco_enable_q,
  input wire logic mux_out_q
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  a_ce_clears: assert property (!chip_enable |=> !regulator_enable_q &&
    !osc_enable_q && !vco_enable_q && !mux_out_q && !ref_clock_output)
    else $error("state survived chip enable low");
  a_reg_follows_ce: assert property (regulator_enable_q |-> $past(chip_enable))
    else $error("regulator on without chip enable");
  a_osc_off_tick: assert property (!osc_enable_q [*2] |->
    !phase_detector_tick_q) else $error("tick while oscillator off");
  a_osc_off_clk: assert property (!osc_enable_q [*3] |->
    !ref_clock_output) else $error("clock output while oscillator off");
  a_fb_floor: assert property (fb_divide_q != 9'h000 |->
    fb_divide_q >= 9'h01F) else $error("feedback modulus below floor");
  a_fb_vco_off: assert property (!vco_enable_q [*2] |->
    fb_divide_q == 9'h000) else $error("feedback runs with synth off");
  // one edge to capture both halves, one more to raise the answer
  a_wr_answer: assert property (s_axi_awvalid && s_axi_awready &&
    s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_rd_answer: assert property (s_axi_arvalid && s_axi_arready |=>
    s_axi_rvalid && !s_axi_arready) else $error("read not answered");
  cover property (!chip_enable ##1 chip_enable);
  cover property ($rose(mux_out_q));
  cover property (phase_detector_tick_q && fb_divide_q != 9'h000);
endmodule
bind fsd_synth_ctrl fsd_synth_ctrl_assertions u_chk (.*);
`default_nettype wire

// [testbench/fsd_host_model.sv]
// host model programming the synthesizer over the register bus
`timescale 1ns/1ns
`default_nettype none
module fsd_host_model (
  input wire logic clk_sys,
  input wire logic mux_out_q,
  output logic [7:0] awaddr,
  output logic awvalid,
  input wire logic awready,
  output logic [31:0] wdata,
  output logic wvalid,
  input wire logic wready,
  input wire logic bvalid,
  output logic bready,
  output logic [7:0] araddr,
  output logic arvalid,
  input wire logic arready,
  input wire logic rvalid,
  output logic rready,
  output logic hang
);
  initial begin
    {awaddr, awvalid, wdata, wvalid, bready} = '0;
    {araddr, arvalid, rready, hang} = '0;
  end
  task automatic wait_ready();
    int n;
    for (n = 0; n < 300 && mux_out_q !== 1'b1; n++) @(posedge clk_sys);
    if (mux_out_q !== 1'b1) hang <= 1'b1;
  endtask
  // released payload is inverted so stale values never look valid
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    int n;
    @(posedge clk_sys);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (awvalid && awready) begin
        awvalid <= 1'b0;
        awaddr <= ~a;
      end
      if (wvalid && wready) begin
        wvalid <= 1'b0;
        wdata <= ~d;
      end
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) hang <= 1'b1;
  endtask
  task automatic rd(input logic [7:0] a);
    int n;
    @(posedge clk_sys);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk_sys);
      if (arvalid && arready) begin
        arvalid <= 1'b0;
        araddr <= ~a;
      end
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 50) hang <= 1'b1;
  endtask
endmodule
`default_nettype wire

// [testbench/fsd_synth_ctrl_tb_top.sv]
// self-checking bench for the synthesizer control block
`timescale 1ns/1ns
`default_nettype none
`include "fsd_regs.svh"
module fsd_synth_ctrl_tb_top;
  logic clk_sys = 1'b0;
  logic rst = 1'b1;
  logic chip_enable = 1'b1;
  logic [7:0] phase_error_ns = 8'h00;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, cw0;
  logic awvalid, awready, wvalid, wready, bvalid, bready, hang;
  logic arvalid, arready, rvalid, rready, regen, osc, rclk, tick;
  logic vco, halve, mux;
  logic [1:0] bresp, rresp, adj;
  logic [3:0] bias;
  logic [8:0] fb;
  logic [33:0] expq[$];
  logic [1:0] bq[$];
  int miscompares = 0;
  int n_compared = 0;
  int c;
  fsd_synth_ctrl #(.REG_READY_CYC(20)) u_dut (.clk_sys(clk_sys), .rst(rst),
    .chip_enable(chip_enable), .phase_error_ns(phase_error_ns),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .regulator_enable_q(regen), .osc_enable_q(osc), .ref_clock_output(rclk),
    .phase_detector_tick_q(tick), .fb_divide_q(fb), .vco_enable_q(vco),
    .vco_halve_enable_q(halve), .vco_adjust_field_q(adj),
    .vco_bias_field_q(bias), .mux_out_q(mux));
  fsd_host_model u_host (.clk_sys(clk_sys), .mux_out_q(mux), .awaddr(awaddr),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wvalid(wvalid),
    .wready(wready), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arvalid(arvalid), .arready(arready), .rvalid(rvalid), .rready(rready),
    .hang(hang));
  initial begin
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic stop_test();
    $display("compared %0d mismatched %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [33:0] e, input logic [33:0] g);
    n_compared++;
    if (g !== e) begin
      miscompares++;
      $display("unexpected %s exp %h got %h", nm, e, g);
    end
  endtask
  task automatic rdx(input logic [7:0] a, input logic [1:0] r,
                     input logic [31:0] e);
    expq.push_back({r, e});
    u_host.rd(a);
  endtask
  task automatic wrx(input logic [7:0] a, input logic [31:0] d,
                     input logic [1:0] r);
    bq.push_back(r);
    u_host.wr(a, d);
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge clk_sys);
  endtask
  // ticks when sel, else changes of the clock output, over 30 cycles
  task automatic cnt(input bit sel, output int n);
    logic p;
    p = rclk;
    n = 0;
    repeat (30) begin
      @(posedge clk_sys);
      if (sel ? tick === 1'b1 : rclk !== p) n++;
      p = rclk;
    end
  endtask
  task automatic ticks(input int k);
    int n;
    for (n = 0; n < 40 && k > 0; n++) begin
      @(posedge clk_sys);
      if (tick === 1'b1) k--;
    end
    if (k > 0) begin
      miscompares++;
      stop_test();
    end
  endtask
  always @(posedge clk_sys) begin
    if (rvalid && rready) begin
      if (expq.size() == 0) chk("read count", 34'h0, 34'h1);
      else chk("read data", expq.pop_front(), {rresp, rdata});
    end
    if (bvalid && bready) begin
      if (bq.size() == 0) chk("write count", 34'h0, 34'h1);
      else chk("write resp", {32'h0, bq.pop_front()}, {32'h0, bresp});
    end
    if (hang) begin
      miscompares++;
      stop_test();
    end
  end
  initial begin
    void'($urandom(32'he03f));
    cyc(4);
    rst <= 1'b0;
    cyc(1);
    // early write is answered but must not land
    wrx(`FSD_CW1_OFS, 32'h0000_0000, `FSD_RESP_OKAY);
    rdx(`FSD_CW0_OFS, `FSD_RESP_OKAY, `FSD_CW0_RST);
    rdx(`FSD_CW1_OFS, `FSD_RESP_OKAY, `FSD_CW1_RST);
    chk("osc enable", {33'h0, osc}, 34'h1);
    u_host.wait_ready();
    rdx(`FSD_STAT_OFS, `FSD_RESP_OKAY, 32'h0000_0001);
    cnt(1'b1, c);
    chk("ref ratio one", 34'(c), 34'd30);
    $display("test defaults done");
    cw0 = {4'h1, 5'h00, 8'($urandom_range(255, 31)), 15'($urandom)};
    wrx(`FSD_CW0_OFS, cw0, `FSD_RESP_OKAY);
    wrx(`FSD_CW1_OFS, 32'h0022_3330, `FSD_RESP_OKAY);
    rdx(`FSD_CW0_OFS, `FSD_RESP_OKAY, cw0);
    rdx(`FSD_CW1_OFS, `FSD_RESP_OKAY, 32'h0022_3330);
    chk("vco pins", {26'h0, vco, halve, adj, bias}, 34'h0E2);
    cnt(1'b1, c);
    chk("detector ticks", 34'(c), 34'd10);
    cnt(1'b0, c);
    chk("clock toggles", 34'(c), 34'd10);
    wrx(`FSD_CW1_OFS, 32'h0022_3030, `FSD_RESP_OKAY);
    cyc(2);
    cnt(1'b0, c);
    chk("clock stopped", {26'h0, 7'(c), rclk}, 34'h0);
    wrx(`FSD_STAT_OFS, 32'hFFFF_FFFF, `FSD_RESP_OKAY);
    wrx(8'h0C, 32'h0000_0000, `FSD_RESP_SLVERR);
    rdx(8'h0C, `FSD_RESP_SLVERR, 32'h0);
    $display("test dividers done");
    wrx(`FSD_CW0_OFS, 32'h1002_8000, `FSD_RESP_OKAY);
    cyc(4);
    chk("modulus floor", {25'h0, fb}, 34'd31);
    rdx(`FSD_CW0_OFS, `FSD_RESP_OKAY, 32'h1002_8000);
    phase_error_ns <= 8'd30;
    wrx(`FSD_CW0_OFS, 32'h3014_0000, `FSD_RESP_OKAY);
    cyc(10);
    chk("modulus int", {25'h0, fb}, 34'd40);
    phase_error_ns <= 8'd10;
    ticks(4);
    cyc(2);
    chk("lock early", {33'h0, mux}, 34'h0);
    ticks(1);
    cyc(2);
    chk("lock set", {33'h0, mux}, 34'h1);
    phase_error_ns <= 8'd20;
    ticks(6);
    cyc(2);
    chk("lock held", {33'h0, mux}, 34'h1);
    phase_error_ns <= 8'd25;
    ticks(1);
    cyc(2);
    chk("lock lost", {33'h0, mux}, 34'h0);
    $display("test lock done");
    chip_enable <= 1'b0;
    cyc(3);
    chk("power down", {29'h0, regen, osc, vco, mux, rclk}, 34'h0);
    chip_enable <= 1'b1;
    cyc(2);
    rdx(`FSD_CW0_OFS, `FSD_RESP_OKAY, `FSD_CW0_RST);
    rdx(`FSD_CW1_OFS, `FSD_RESP_OKAY, `FSD_CW1_RST);
    u_host.wait_ready();
    chk("ready shown", {32'h0, regen, mux}, 34'h3);
    $display("test power cycle done");
    cyc(4);
    stop_test();
  end
endmodule
`default_nettype wire
